// *** canet_bit_timing.sv ***
`include "canet_cfg.svh"
`default_nettype none
module canet_bit_timing
  import canet_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // synchronised bus level
  input wire logic rx,
  // timing setup, each length field holds length minus one
  input wire logic [5:0] prescale,
  input wire logic [1:0] prop_segment_length,
  input wire logic [3:0] phase1_length,
  input wire logic [2:0] phase2_length,
  input wire logic [1:0] resync_jump_width,
  input wire logic low_speed,
  input wire logic hard_sync_en,
  // bit strobes
  output logic bit_start,
  output logic sample,
  output logic rx_bit
);

  logic [5:0] pre_cnt, next_pre_cnt;
  logic [4:0] q, next_q;
  logic rx_prev, next_rx_prev;
  logic next_bit_start, next_sample, next_rx_bit;
  logic bit_time_quantum_clock;
  logic [4:0] ph1_end, last_q, jump_width_window;
  logic edge_seen, edge_ok, early, late;

  always_comb begin
    bit_time_quantum_clock = (pre_cnt == prescale);
    next_pre_cnt = bit_time_quantum_clock ? '0 : pre_cnt + `CANET_PRE_STEP;
    ph1_end = 5'(prop_segment_length) + 5'(phase1_length) + `CANET_PH1_OFS;
    last_q = ph1_end + 5'(phase2_length) + `CANET_ONE_TQ;
    jump_width_window = 5'(resync_jump_width) + `CANET_ONE_TQ;
    edge_seen = bit_time_quantum_clock && (rx != rx_prev);
    // only falling edges unless the slow mode also trusts rising ones
    edge_ok = edge_seen && (!rx || low_speed);
    early = (q > ph1_end) && (q > last_q - jump_width_window);
    late = (q != '0) && (q <= jump_width_window);
    next_rx_prev = bit_time_quantum_clock ? rx : rx_prev;
    next_q = q;
    next_bit_start = 1'b0;
    next_sample = 1'b0;
    next_rx_bit = rx_bit;
    if (bit_time_quantum_clock) begin
      if (hard_sync_en && edge_seen && !rx) begin
        next_q = `CANET_SYNC_NEXT;
        next_bit_start = 1'b1;
      end else if (!hard_sync_en && edge_ok && (early || late)) begin
        next_q = `CANET_SYNC_NEXT;
        next_bit_start = early;
      end else if (q == last_q) begin
        next_q = '0;
        next_bit_start = 1'b1;
      end else begin
        next_q = q + `CANET_ONE_TQ;
        if (q == ph1_end) begin
          next_sample = 1'b1;
          next_rx_bit = rx;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= '0;
      q <= '0;
      rx_prev <= `CANET_RECESSIVE;
      bit_start <= 1'b0;
      sample <= 1'b0;
      rx_bit <= `CANET_RECESSIVE;
    end else begin
      pre_cnt <= next_pre_cnt;
      q <= next_q;
      rx_prev <= next_rx_prev;
      bit_start <= next_bit_start;
      sample <= next_sample;
      rx_bit <= next_rx_bit;
    end
  end

endmodule
`default_nettype wire

// *** canet_bus_peer.sv ***
`default_nettype none
module canet_bus_peer (
  // node under test and far-side drive
  input wire logic tx_pin,
  input wire logic drv,
  // shared bus, recessive high
  output logic bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // wired-and: dominant from anyone wins, acks need no extra logic
  assign bus = tx_pin & drv;
endmodule
`default_nettype wire

// *** canet_cfg.svh ***
`ifndef CANET_CFG_SVH
`define CANET_CFG_SVH

// bus levels
`define CANET_RECESSIVE 1'h1
`define CANET_DOMINANT 1'h0

// bit timing: quantum index of the first quantum after sync
`define CANET_SYNC_NEXT 5'h01
`define CANET_PH1_OFS 5'h02
`define CANET_ONE_TQ 5'h01
`define CANET_PRE_STEP 6'h01

// stuff run: the sixth equal bit is an error
`define CANET_STUFF_LAST 3'h5
`define CANET_RUN_STEP 3'h1

// error and overload frame shape
`define CANET_FLAG_LAST 5'h05
`define CANET_DELIM_LAST 5'h07
`define CANET_DOM_ACTIVE 5'h10
`define CANET_DOM_PASSIVE 5'h08
`define CANET_DOM_STEP 5'h08
`define CANET_CNT_STEP 5'h01

// bus-off recovery: 11 recessive bits, 128 times
`define CANET_IDLE_RUN_LAST 4'ha
`define CANET_IDLE_SEQ_LAST 8'h7f

// crc
`define CANET_CRC_POLY 15'h4599
`define CANET_CRC_INIT 15'h0000

// error counters
`define CANET_INC_NONE 4'h0
`define CANET_INC_ONE 4'h1
`define CANET_INC_EIGHT 4'h8
`define CANET_PASSIVE_LVL 9'h080
`define CANET_BUSOFF_LVL 9'h100
`define CANET_RX_CAP 9'h07f
`define CANET_STARTUP_TX 9'h0ff
`define CANET_CNT_MAX 9'h1ff
`define CANET_CNT_ZERO 9'h000
`define CANET_CNT_ONE 9'h001

`endif

// *** canet_error_ctrl.sv ***
`include "canet_cfg.svh"
`default_nettype none
module canet_error_ctrl
  import canet_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WAKEUP,
  // bus pins
  input wire logic RX_PIN,
  output logic TX_PIN,
  // bit timing setup
  input wire logic [5:0] PRESCALE,
  input wire logic [1:0] PROP_SEGMENT_LENGTH,
  input wire logic [3:0] PHASE1_LENGTH,
  input wire logic [2:0] PHASE2_LENGTH,
  input wire logic [1:0] RESYNC_JUMP_WIDTH,
  input wire logic LOW_SPEED,
  // frame formatter
  input wire canet_field_t FMT_FIELD,
  input wire logic FMT_TX_ACTIVE,
  input wire logic FMT_TX_BIT,
  input wire logic FMT_STUFF_BIT,
  input wire logic FMT_TRANSMITTER,
  input wire logic FMT_FRAME_OK,
  output logic BIT_START,
  output logic SAMPLE_POINT,
  output logic RX_BIT,
  // error status
  output var canet_err_state_t ERR_STATE,
  output logic [8:0] TX_ERR_COUNT,
  output logic [8:0] RECEIVE_ERROR_COUNT,
  output logic ERR_FRAME_ACTIVE,
  output logic OVERLOAD_ACTIVE,
  output logic RETRANSMIT,
  output logic [4:0] ERR_KIND
);

  function automatic logic [8:0] sat_add(input logic [8:0] v,
                                         input logic [3:0] inc);
    logic [9:0] s;
    s = {1'b0, v} + 10'(inc);
    return s[9] ? `CANET_CNT_MAX : s[8:0];
  endfunction

  function automatic canet_err_state_t err_of(input logic [8:0] t,
                                              input logic [8:0] r,
                                              input logic boot);
    if (boot) return ERR_PASSIVE;
    if (t >= `CANET_BUSOFF_LVL) return BUS_OFF;
    if (t >= `CANET_PASSIVE_LVL || r >= `CANET_PASSIVE_LVL) return ERR_PASSIVE;
    return ERR_ACTIVE;
  endfunction

  function automatic logic [14:0] crc_step(input logic [14:0] c,
                                           input logic b);
    return (b ^ c[14]) ? ({c[13:0], 1'b0} ^ `CANET_CRC_POLY)
                       : {c[13:0], 1'b0};
  endfunction

  logic rx_meta, rx_sync, next_rx_meta, next_rx_sync;
  canet_fsm_t fsm, next_fsm;
  canet_err_state_t next_es;
  logic next_tx, startup, next_startup;
  logic [8:0] next_tec, next_rxc;
  logic [2:0] run_cnt, next_run_cnt;
  logic run_lvl, next_run_lvl;
  logic [14:0] crc, next_crc, crc_rx, next_crc_rx;
  logic crc_bad, next_crc_bad;
  logic pend, next_pend, pend_ovl, next_pend_ovl, pend_pas, next_pend_pas;
  logic [3:0] pend_tec, next_pend_tec, pend_rxc, next_pend_rxc;
  logic was_tx, next_was_tx, ack_exc, next_ack_exc;
  logic is_ovl, next_is_ovl, pas_flag, next_pas_flag;
  logic [4:0] cnt, next_cnt;
  logic dom_seen, next_dom_seen, first, next_first;
  logic [3:0] idle_run, next_idle_run;
  logic [7:0] idle_seqs, next_idle_seqs;
  logic [4:0] next_err_kind;
  logic next_retx, next_busy;
  logic in_stf, in_crc, interm, e_bit, e_stuff, e_crc, e_form, e_ack;
  logic dom, flag_end;
  logic [4:0] dom_lim;

  canet_bit_timing u_timing (
    .clk(CLK),
    .rst(SYS_RST),
    .rx(rx_sync),
    .prescale(PRESCALE),
    .prop_segment_length(PROP_SEGMENT_LENGTH),
    .phase1_length(PHASE1_LENGTH),
    .phase2_length(PHASE2_LENGTH),
    .resync_jump_width(RESYNC_JUMP_WIDTH),
    .low_speed(LOW_SPEED),
    .hard_sync_en(FMT_FIELD == FLD_IDLE && fsm == ST_NORMAL),
    .bit_start(BIT_START),
    .sample(SAMPLE_POINT),
    .rx_bit(RX_BIT)
  );

  always_comb begin
    next_rx_meta = RX_PIN;
    next_rx_sync = rx_meta;
    next_fsm = fsm;
    next_tec = TX_ERR_COUNT;
    next_rxc = RECEIVE_ERROR_COUNT;
    next_startup = startup;
    next_run_cnt = run_cnt;
    next_run_lvl = run_lvl;
    next_crc = crc;
    next_crc_rx = crc_rx;
    next_crc_bad = crc_bad;
    next_pend = pend;
    next_pend_ovl = pend_ovl;
    next_pend_pas = pend_pas;
    next_pend_tec = pend_tec;
    next_pend_rxc = pend_rxc;
    next_was_tx = was_tx;
    next_ack_exc = ack_exc;
    next_is_ovl = is_ovl;
    next_pas_flag = pas_flag;
    next_cnt = cnt;
    next_dom_seen = dom_seen;
    next_first = first;
    next_idle_run = idle_run;
    next_idle_seqs = idle_seqs;
    next_err_kind = '0;
    next_retx = 1'b0;
    dom = (RX_BIT == `CANET_DOMINANT);
    in_crc = FMT_FIELD inside {FLD_ARB, FLD_DATA};
    in_stf = in_crc || FMT_FIELD == FLD_CRC_SEQ;
    interm = FMT_FIELD == FLD_INTERMISSION;
    // recessive sent, dominant read back: lost priority in arbitration, an ack in the ack slot
    e_bit = FMT_TX_ACTIVE && ERR_STATE != BUS_OFF && !FMT_STUFF_BIT &&
            TX_PIN != RX_BIT && !(TX_PIN == `CANET_RECESSIVE &&
            FMT_FIELD inside {FLD_ARB, FLD_ACK_SLOT});
    e_stuff = in_stf && RX_BIT == run_lvl &&
              run_cnt == `CANET_STUFF_LAST;
    e_crc = crc_bad && FMT_FIELD == FLD_ACK_DEL;
    e_form = !FMT_TRANSMITTER && dom &&
             FMT_FIELD inside {FLD_CRC_DEL, FLD_ACK_DEL, FLD_EOF};
    e_ack = FMT_TRANSMITTER && FMT_FIELD == FLD_ACK_SLOT && !dom;
    flag_end = 1'b0;
    dom_lim = pas_flag ? `CANET_DOM_PASSIVE : `CANET_DOM_ACTIVE;

    if (BIT_START && pend) begin
      next_pend = 1'b0;
      next_fsm = ST_FLAG;
      next_cnt = '0;
      next_run_cnt = '0;
      next_dom_seen = 1'b0;
      next_is_ovl = pend_ovl;
      next_pas_flag = !pend_ovl && pend_pas;
      next_tec = sat_add(next_tec, pend_tec);
      next_rxc = sat_add(next_rxc, pend_rxc);
    end else if (SAMPLE_POINT) begin
      case (fsm)
        ST_NORMAL: begin
          if (!in_stf) begin
            next_run_cnt = '0;
          end else if (RX_BIT == run_lvl && run_cnt != '0) begin
            next_run_cnt = run_cnt + `CANET_RUN_STEP;
          end else begin
            next_run_cnt = `CANET_RUN_STEP;
            next_run_lvl = RX_BIT;
          end
          if (FMT_FIELD == FLD_IDLE || interm) begin
            next_crc = `CANET_CRC_INIT;
            next_crc_rx = `CANET_CRC_INIT;
            // a verdict from a frame cut short must not leak into the next
            next_crc_bad = 1'b0;
          end else if (in_crc && !FMT_STUFF_BIT) begin
            next_crc = crc_step(crc, RX_BIT);
          end else if (FMT_FIELD == FLD_CRC_SEQ && !FMT_STUFF_BIT) begin
            next_crc_rx = {crc_rx[13:0], RX_BIT};
          end
          if (FMT_FIELD == FLD_CRC_DEL && !FMT_TRANSMITTER && crc != crc_rx)
            next_crc_bad = 1'b1;
          if (e_crc)
            next_crc_bad = 1'b0;
          if (FMT_TRANSMITTER && FMT_FIELD == FLD_ACK_SLOT && dom &&
              startup) begin
            next_startup = 1'b0;
            next_tec = `CANET_CNT_ZERO;
          end
          if (!pend && (e_bit || e_stuff || e_crc || e_form || e_ack)) begin
            next_pend = 1'b1;
            next_pend_ovl = interm && e_bit;
            next_pend_pas = ERR_STATE != ERR_ACTIVE;
            next_was_tx = FMT_TRANSMITTER;
            next_ack_exc = e_ack && ERR_STATE != ERR_ACTIVE;
            next_err_kind = {e_ack, e_form, e_crc, e_stuff, e_bit};
            next_pend_tec = `CANET_INC_NONE;
            next_pend_rxc = `CANET_INC_NONE;
            if (!next_pend_ovl && FMT_TRANSMITTER &&
                !(e_stuff && FMT_FIELD == FLD_ARB) && !next_ack_exc)
              next_pend_tec = `CANET_INC_EIGHT;
            if (!next_pend_ovl && !FMT_TRANSMITTER)
              next_pend_rxc = `CANET_INC_ONE;
          end
        end
        ST_FLAG: begin
          next_cnt = cnt + `CANET_CNT_STEP;
          if (!pas_flag) begin
            if (!dom) begin
              next_err_kind = 5'h01;
              if (was_tx) next_tec = sat_add(next_tec, `CANET_INC_EIGHT);
              else next_rxc = sat_add(next_rxc, `CANET_INC_EIGHT);
            end
            flag_end = cnt == `CANET_FLAG_LAST;
          end else begin
            // passive flag ends only after six equal bits of any level
            if (RX_BIT == run_lvl && run_cnt != '0) begin
              next_run_cnt = run_cnt + `CANET_RUN_STEP;
            end else begin
              next_run_cnt = `CANET_RUN_STEP;
              next_run_lvl = RX_BIT;
            end
            if (dom) next_dom_seen = 1'b1;
            if (dom && !dom_seen && ack_exc)
              next_tec = sat_add(next_tec, `CANET_INC_EIGHT);
            flag_end = RX_BIT == run_lvl && run_cnt == `CANET_STUFF_LAST;
          end
          if (flag_end) begin
            next_fsm = ST_FLAG_WAIT;
            next_cnt = '0;
            next_first = 1'b1;
          end
        end
        ST_FLAG_WAIT: begin
          next_first = 1'b0;
          if (dom) begin
            if (first && !was_tx && !is_ovl)
              next_rxc = sat_add(next_rxc, `CANET_INC_EIGHT);
            next_cnt = cnt + `CANET_CNT_STEP;
            if (next_cnt == dom_lim) begin
              next_tec = sat_add(next_tec, `CANET_INC_EIGHT);
              next_rxc = sat_add(next_rxc, `CANET_INC_EIGHT);
              next_cnt = dom_lim - `CANET_DOM_STEP;
            end
          end else begin
            next_fsm = ST_DELIM;
            next_cnt = `CANET_CNT_STEP;
          end
        end
        ST_DELIM: begin
          if (dom) begin
            // dominant on the last delimiter bit asks for overload
            next_fsm = ST_NORMAL;
            next_pend = 1'b1;
            next_pend_ovl = cnt == `CANET_DELIM_LAST;
            next_pend_pas = ERR_STATE != ERR_ACTIVE;
            next_ack_exc = 1'b0;
            next_err_kind = next_pend_ovl ? '0 : 5'h08;
            next_pend_tec = (!next_pend_ovl && was_tx) ?
                            `CANET_INC_EIGHT : `CANET_INC_NONE;
            next_pend_rxc = (!next_pend_ovl && !was_tx) ?
                            `CANET_INC_ONE : `CANET_INC_NONE;
          end else if (cnt == `CANET_DELIM_LAST) begin
            next_fsm = ST_NORMAL;
            next_retx = was_tx && !is_ovl;
          end else begin
            next_cnt = cnt + `CANET_CNT_STEP;
          end
        end
        ST_BUSOFF: begin
          // reception stays live here; only the driver is silenced
          if (dom) begin
            next_idle_run = '0;
          end else if (idle_run == `CANET_IDLE_RUN_LAST) begin
            next_idle_run = '0;
            next_idle_seqs = idle_seqs + 8'h01;
            if (idle_seqs == `CANET_IDLE_SEQ_LAST) begin
              next_fsm = ST_NORMAL;
              next_tec = `CANET_CNT_ZERO;
              next_rxc = `CANET_CNT_ZERO;
            end
          end else begin
            next_idle_run = idle_run + 4'h1;
          end
        end
        default: next_fsm = ST_NORMAL;
      endcase
    end

    if (FMT_FRAME_OK && fsm == ST_NORMAL) begin
      if (FMT_TRANSMITTER) begin
        if (next_tec != `CANET_CNT_ZERO)
          next_tec = next_tec - `CANET_CNT_ONE;
      end else if (next_rxc > `CANET_RX_CAP) begin
        next_rxc = `CANET_RX_CAP;
      end else if (next_rxc != `CANET_CNT_ZERO) begin
        next_rxc = next_rxc - `CANET_CNT_ONE;
      end
    end
    if (fsm == ST_NORMAL && next_fsm == ST_NORMAL && !next_pend &&
        ERR_STATE == BUS_OFF) begin
      next_fsm = ST_BUSOFF;
      next_idle_run = '0;
      next_idle_seqs = '0;
    end
    if (WAKEUP) begin
      next_startup = 1'b1;
      next_pend = 1'b0;
      next_fsm = ST_NORMAL;
    end
    // the boot latch pins the count so a lone node cannot go bus off
    if (next_startup) next_tec = `CANET_STARTUP_TX;
    next_es = err_of(next_tec, next_rxc, next_startup);
    next_busy = next_fsm inside {ST_FLAG, ST_FLAG_WAIT, ST_DELIM};
    next_tx = TX_PIN;
    if (BIT_START) begin
      if (next_fsm == ST_FLAG)
        next_tx = next_pas_flag ? `CANET_RECESSIVE : `CANET_DOMINANT;
      else if (next_fsm == ST_NORMAL && FMT_TX_ACTIVE && next_es != BUS_OFF)
        next_tx = FMT_TX_BIT;
      else
        next_tx = `CANET_RECESSIVE;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rx_meta <= `CANET_RECESSIVE;
      rx_sync <= `CANET_RECESSIVE;
      fsm <= ST_NORMAL;
      TX_PIN <= `CANET_RECESSIVE;
      TX_ERR_COUNT <= `CANET_STARTUP_TX;
      RECEIVE_ERROR_COUNT <= `CANET_CNT_ZERO;
      ERR_STATE <= ERR_PASSIVE;
      startup <= 1'b1;
      run_cnt <= '0;
      run_lvl <= `CANET_RECESSIVE;
      crc <= `CANET_CRC_INIT;
      crc_rx <= `CANET_CRC_INIT;
      crc_bad <= 1'b0;
      pend <= 1'b0;
      pend_ovl <= 1'b0;
      pend_pas <= 1'b0;
      pend_tec <= `CANET_INC_NONE;
      pend_rxc <= `CANET_INC_NONE;
      was_tx <= 1'b0;
      ack_exc <= 1'b0;
      is_ovl <= 1'b0;
      pas_flag <= 1'b0;
      cnt <= '0;
      dom_seen <= 1'b0;
      first <= 1'b0;
      idle_run <= '0;
      idle_seqs <= '0;
      ERR_KIND <= '0;
      RETRANSMIT <= 1'b0;
      ERR_FRAME_ACTIVE <= 1'b0;
      OVERLOAD_ACTIVE <= 1'b0;
    end else begin
      rx_meta <= next_rx_meta;
      rx_sync <= next_rx_sync;
      fsm <= next_fsm;
      TX_PIN <= next_tx;
      TX_ERR_COUNT <= next_tec;
      RECEIVE_ERROR_COUNT <= next_rxc;
      ERR_STATE <= next_es;
      startup <= next_startup;
      run_cnt <= next_run_cnt;
      run_lvl <= next_run_lvl;
      crc <= next_crc;
      crc_rx <= next_crc_rx;
      crc_bad <= next_crc_bad;
      pend <= next_pend;
      pend_ovl <= next_pend_ovl;
      pend_pas <= next_pend_pas;
      pend_tec <= next_pend_tec;
      pend_rxc <= next_pend_rxc;
      was_tx <= next_was_tx;
      ack_exc <= next_ack_exc;
      is_ovl <= next_is_ovl;
      pas_flag <= next_pas_flag;
      cnt <= next_cnt;
      dom_seen <= next_dom_seen;
      first <= next_first;
      idle_run <= next_idle_run;
      idle_seqs <= next_idle_seqs;
      ERR_KIND <= next_err_kind;
      RETRANSMIT <= next_retx;
      ERR_FRAME_ACTIVE <= next_busy;
      OVERLOAD_ACTIVE <= next_busy && next_is_ovl;
    end
  end

endmodule
`default_nettype wire

// *** canet_error_ctrl_props.sv ***
`default_nettype none
module canet_err_chk
  import canet_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // watched ports
  input wire logic FMT_TRANSMITTER,
  input wire logic TX_PIN,
  input wire logic BIT_START,
  input wire logic SAMPLE_POINT,
  input wire logic RX_BIT,
  input wire canet_err_state_t ERR_STATE,
  input wire logic [8:0] TX_ERR_COUNT,
  input wire logic [8:0] RECEIVE_ERROR_COUNT,
  input wire logic ERR_FRAME_ACTIVE,
  input wire logic RETRANSMIT,
  input wire logic [4:0] ERR_KIND
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend, act, ack, rxe, due;
  logic next_pend, next_act, next_ack, next_rxe;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // flag owed at the first bit start from the error pulse on; the pulse
  // may share its cycle with that bit start, so it counts at once
  always_comb begin
    next_pend = pend;
    next_act = act;
    next_ack = ack;
    next_rxe = rxe;
    if (|ERR_KIND && !ERR_FRAME_ACTIVE) begin
      next_pend = 1'h1;
      next_act = ERR_STATE == ERR_ACTIVE;
      next_ack = ERR_KIND[4];
      next_rxe = !FMT_TRANSMITTER && !ERR_KIND[0];
    end
    due = BIT_START && next_pend;
    if (BIT_START) next_pend = 1'h0;
  end
  always_ff @(posedge CLK) begin
    pend <= SYS_RST ? 1'h0 : next_pend;
    act <= next_act;
    ack <= next_ack;
    rxe <= next_rxe;
  end
  a_reset_counts: assert property (
    $fell(SYS_RST) |-> TX_ERR_COUNT == 9'h0ff && RECEIVE_ERROR_COUNT == 9'h000
  ) else $error("counters wrong after reset");
  a_active_range: assert property (
    $past(TX_ERR_COUNT) >= 9'h080 && TX_ERR_COUNT >= 9'h080
      |-> ERR_STATE != ERR_ACTIVE
  ) else $error("active with high count");
  a_busoff_quiet: assert property (
    ERR_STATE == BUS_OFF ##1 ERR_STATE == BUS_OFF |-> TX_PIN
  ) else $error("driving while off the bus");
  a_tx_at_bit: assert property (
    $changed(TX_PIN) |-> $past(BIT_START)
  ) else $error("tx changed off bit start");
  a_sample_hold: assert property (
    $changed(RX_BIT) |-> SAMPLE_POINT
  ) else $error("rx bit changed off sample");
  a_retx_pulse: assert property (
    RETRANSMIT |-> $past(ERR_FRAME_ACTIVE) ##1 !RETRANSMIT
  ) else $error("retransmit misplaced");
  a_flag_level: assert property (
    due |=> TX_PIN == !act
  ) else $error("flag level wrong");
  a_ack_plus8: assert property (
    due && next_act && next_ack
      |=> TX_ERR_COUNT == $past(TX_ERR_COUNT) + 9'h008
  ) else $error("tx count not raised by 8");
  a_rx_plus1: assert property (
    due && next_rxe && !next_ack
      |=> RECEIVE_ERROR_COUNT == $past(RECEIVE_ERROR_COUNT) + 9'h001
  ) else $error("rx count not raised by 1");
endmodule
bind canet_error_ctrl canet_err_chk u_canet_err_chk (.CLK(CLK),
  .SYS_RST(SYS_RST), .FMT_TRANSMITTER(FMT_TRANSMITTER), .TX_PIN(TX_PIN),
  .BIT_START(BIT_START), .SAMPLE_POINT(SAMPLE_POINT), .RX_BIT(RX_BIT),
  .ERR_STATE(ERR_STATE), .TX_ERR_COUNT(TX_ERR_COUNT),
  .RECEIVE_ERROR_COUNT(RECEIVE_ERROR_COUNT),
  .ERR_FRAME_ACTIVE(ERR_FRAME_ACTIVE), .RETRANSMIT(RETRANSMIT),
  .ERR_KIND(ERR_KIND));
`default_nettype wire

// *** canet_pkg.sv ***
`default_nettype none
package canet_pkg;

  // frame position as reported by the frame formatter
  typedef enum logic [3:0] {
    FLD_IDLE, FLD_ARB, FLD_DATA, FLD_CRC_SEQ, FLD_CRC_DEL,
    FLD_ACK_SLOT, FLD_ACK_DEL, FLD_EOF, FLD_INTERMISSION
  } canet_field_t;

  typedef enum logic [1:0] {
    ERR_ACTIVE, ERR_PASSIVE, BUS_OFF
  } canet_err_state_t;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_FLAG, ST_FLAG_WAIT, ST_DELIM, ST_BUSOFF
  } canet_fsm_t;

endpackage
`default_nettype wire

// *** tb_canet_error_ctrl.sv ***
`default_nettype none
module tb_canet_error_ctrl
  import canet_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, wake = 1'h0, ls = 1'h0, drv = 1'h1;
  logic txa = 1'h0, tbit = 1'h1, st = 1'h0, xm = 1'h0, ok = 1'h0;
  logic tx, bs, sp, rb, efa, rtx;
  logic [5:0] pre = 6'h00;
  logic [1:0] prp = 2'h0, rjw = 2'h3;
  logic [3:0] ph1 = 4'h3;
  logic [2:0] ph2 = 3'h0;
  logic [4:0] kind, k;
  logic [8:0] tec, rxc;
  logic [14:0] tbl [3] = '{{6'h00, 2'h0, 4'h3, 3'h0},
    {6'h01, 2'h1, 4'h2, 3'h1}, {6'h3f, 2'h3, 4'hf, 3'h7}};
  canet_field_t fld = FLD_IDLE;
  canet_err_state_t est;
  wire logic rxp;
  int error_cnt = 0, tests_run = 0, n, i;
  always #50 clk = ~clk;
  canet_bus_peer u_canet_bus_peer (.tx_pin(tx), .drv(drv), .bus(rxp));
  canet_error_ctrl u_canet_error_ctrl (.CLK(clk), .SYS_RST(rst),
    .WAKEUP(wake), .RX_PIN(rxp), .TX_PIN(tx), .PRESCALE(pre),
    .PROP_SEGMENT_LENGTH(prp), .PHASE1_LENGTH(ph1), .PHASE2_LENGTH(ph2),
    .RESYNC_JUMP_WIDTH(rjw), .LOW_SPEED(ls), .FMT_FIELD(fld),
    .FMT_TX_ACTIVE(txa), .FMT_TX_BIT(tbit), .FMT_STUFF_BIT(st),
    .FMT_TRANSMITTER(xm), .FMT_FRAME_OK(ok), .BIT_START(bs),
    .SAMPLE_POINT(sp), .RX_BIT(rb), .ERR_STATE(est), .TX_ERR_COUNT(tec),
    .RECEIVE_ERROR_COUNT(rxc), .ERR_FRAME_ACTIVE(efa),
    .OVERLOAD_ACTIVE(), .RETRANSMIT(rtx), .ERR_KIND(kind));
  task close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task step();
    @(posedge clk);
    #1;
  endtask
  // 0 bit start, 1 sample, 2 retransmit, 3 error frame over
  task wt(input int w);
    n = 0;
    do begin
      step();
      n++;
    end while (!(w == 0 ? bs : w == 1 ? sp : w == 2 ? rtx : !efa)
      && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      $display("[ERR] wait %0d exp done got timeout", w);
      close_out();
    end
  endtask
  // inputs set in the bit start cycle, kind taken after the sample;
  // a bit start already showing is used, else a whole bit would repeat
  task one_bit(input canet_field_t f, input logic a, b, d);
    if (!bs) wt(0);
    fld = f;
    txa = a;
    tbit = b;
    drv = d;
    wt(1);
    step();
    k = kind;
  endtask
  task txfr(input logic ackd);
    xm = 1'h1;
    one_bit(FLD_ARB, 1'h1, 1'h0, 1'h1);
    one_bit(FLD_ARB, 1'h1, 1'h1, 1'h1);
    one_bit(FLD_ACK_SLOT, 1'h0, 1'h1, !ackd);
  endtask
  task fok();
    ok = 1'h1;
    step();
    ok = 1'h0;
    repeat (3) step();
  endtask
  initial begin
    repeat (20) step();
    rst = 1'h0;
    step();
    chk("tx count", 16'h00ff, tec);
    chk("rx count", 16'h0000, rxc);
    chk("state", 16'(ERR_PASSIVE), 16'(est));
    chk("tx pin", 16'h0001, 16'(tx));
    for (i = 0; i < 3; i++) begin
      {pre, prp, ph1, ph2} = tbl[i];
      wt(0);
      wt(0);
      chk("bit clocks", (pre + 16'h1) * (prp + ph1 + ph2 + 16'h4), 16'(n));
    end
    {pre, prp, ph1, ph2} = tbl[0];
    wt(0);
    $display("timing done");
    txfr(1'h0);
    chk("ack kind", 16'h0010, 16'(k));
    one_bit(FLD_IDLE, 1'h0, 1'h1, 1'h1);
    chk("passive flag", 16'h0001, 16'(tx));
    chk("tx count", 16'h00ff, tec);
    wt(2);
    $display("boot done");
    txfr(1'h1);
    one_bit(FLD_ACK_DEL, 1'h0, 1'h1, 1'h1);
    fok();
    chk("tx count", 16'h0000, tec);
    chk("state", 16'(ERR_ACTIVE), 16'(est));
    txfr(1'h0);
    chk("ack kind", 16'h0010, 16'(k));
    one_bit(FLD_IDLE, 1'h0, 1'h1, 1'h1);
    chk("active flag", 16'h0000, 16'(tx));
    chk("tx count", 16'h0008, tec);
    wt(2);
    fok();
    chk("tx count", 16'h0007, tec);
    $display("transmit done");
    xm = 1'h0;
    one_bit(FLD_ARB, 1'h0, 1'h1, 1'h0);
    one_bit(FLD_ARB, 1'h0, 1'h1, 1'h1);
    for (i = 1; i < 7; i++) begin
      one_bit(FLD_DATA, 1'h0, 1'h1, 1'h0);
      chk("stuff kind", i == 6 ? 16'h0002 : 16'h0000, 16'(k));
    end
    one_bit(FLD_IDLE, 1'h0, 1'h1, 1'h1);
    chk("rx count", 16'h0001, rxc);
    wt(3);
    one_bit(FLD_ARB, 1'h0, 1'h1, 1'h0);
    one_bit(FLD_CRC_DEL, 1'h0, 1'h1, 1'h0);
    chk("form kind", 16'h0008, 16'(k));
    one_bit(FLD_IDLE, 1'h0, 1'h1, 1'h1);
    chk("rx count", 16'h0002, rxc);
    wt(3);
    fok();
    chk("rx count", 16'h0001, rxc);
    $display("receive done");
    ls = 1'h1;
    one_bit(FLD_ARB, 1'h0, 1'h1, 1'h0);
    drv = 1'h1;
    wt(0);
    chk("rising resync", 16'h0009, 16'(n));
    ls = 1'h0;
    one_bit(FLD_ARB, 1'h0, 1'h1, 1'h0);
    drv = 1'h1;
    wt(0);
    chk("rising ignored", 16'h0007, 16'(n));
    $display("resync done");
    wake = 1'h1;
    step();
    wake = 1'h0;
    step();
    chk("wake tx count", 16'h00ff, tec);
    chk("wake state", 16'(ERR_PASSIVE), 16'(est));
    $display("wake done");
    close_out();
  end
endmodule
`default_nettype wire
